// *** hdl/sgcr_pkg.sv ***
// sgcr_pkg: offsets, field positions, reset values and size limits
// for the switch global control register slice.
// assumes an 8-bit register port addressed at the printed offsets.
package sgcr_pkg;

   // register offsets
   localparam logic [7:0] SGCR_OFS_CTL2 = 8'h04;
   localparam logic [7:0] SGCR_OFS_FWD  = 8'h05;  // global_forwarding_features
   localparam logic [7:0] SGCR_OFS_CPU  = 8'h06;  // global_cpu_port_settings

   // frame size control (offset 0x04)
   localparam int SGCR_B_HUGE  = 2;
   localparam int SGCR_B_LEGAL = 1;
   localparam logic [7:0] SGCR_CTL2_RST  = 8'h00;
   localparam logic [7:0] SGCR_CTL2_MASK = 8'h07;  // bit 0 is reserved r/w

   // global_forwarding_features fields
   localparam int SGCR_B_VLAN  = 7;
   localparam int SGCR_B_SNOOP = 6;
   localparam int SGCR_B_WFQ   = 3;
   localparam int SGCR_B_SNIFF = 0;
   localparam logic [7:0] SGCR_FWD_RST  = 8'h00;
   localparam logic [7:0] SGCR_FWD_MASK = 8'hc9;

   // global_cpu_port_settings fields
   localparam int SGCR_B_HALF  = 6;
   localparam int SGCR_B_FLOW  = 5;
   localparam int SGCR_B_LOW   = 4;
   localparam int SGCR_B_NULLV = 3;
   localparam logic [7:0] SGCR_CPU_RST  = 8'h20;
   localparam logic [7:0] SGCR_CPU_MASK = 8'h78;

   // frame length limits in bytes
   localparam logic [10:0] SGCR_LEN_ANY      = 11'h600;  // 1536
   localparam logic [10:0] SGCR_LEN_TAGGED   = 11'h5f2;  // 1522
   localparam logic [10:0] SGCR_LEN_UNTAGGED = 11'h5ee;  // 1518
   localparam logic [10:0] SGCR_LEN_HUGE     = 11'h77c;  // 1916

   // weighted fair queuing, queue 3 first
   localparam logic [3:0][4:0] SGCR_WFQ_WEIGHT = {5'h08, 5'h04, 5'h02, 5'h01};
   localparam logic [11:0] SGCR_NULL_VID = 12'h000;

endpackage : sgcr_pkg

// *** hdl/sgcr_egress_sched.sv ***
// sgcr_egress_sched: picks the next egress queue of one port.
// assumes slot is a one-cycle request and q_ready is stable for it.
`timescale 1ns/1ns
`default_nettype none
module sgcr_egress_sched
   import sgcr_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst_q,
   input  wire logic       wfq_on,
   input  wire logic       method_rr,
   input  wire logic [3:0] q_ready,
   input  wire logic       slot,
   output logic            pick_valid,
   output logic [1:0]      pick_q
);

   logic [3:0][4:0] credit;
   logic [3:0][4:0] wt;
   logic [3:0][4:0] base;
   logic [3:0][4:0] next_credit;
   logic [1:0]      rr_ptr;
   logic [1:0]      sel_q;
   logic            sel_ok;
   logic            fresh;
   logic [1:0]      top_q;
   logic [1:0]      idx;

   // round weights: empty queues get none, top busy queue one extra unless all four are busy
   always_comb
   begin
      top_q = 2'h0;
      wt    = '0;
      for (int i = 0; i < 4; i++)
      begin
         if (q_ready[i])
         begin
            wt[i] = SGCR_WFQ_WEIGHT[i];
            top_q = 2'(i);
         end
      end
      if (!(&q_ready) && |q_ready)
         wt[top_q] = wt[top_q] + 5'h01;
   end

   // choose queue by active method
   always_comb
   begin
      fresh = 1'b1;
      for (int i = 0; i < 4; i++)
         if (q_ready[i] && credit[i] != 5'h00)
            fresh = 1'b0;
      base        = fresh ? wt : credit;
      sel_q       = 2'h0;
      sel_ok      = 1'b0;
      idx         = 2'h0;
      if (wfq_on)
      begin
         for (int i = 0; i < 4; i++)
            if (q_ready[i] && base[i] != 5'h00)
            begin
               sel_q  = 2'(i);
               sel_ok = 1'b1;
            end
      end
      else if (method_rr)
      begin
         for (int k = 4; k >= 1; k--)
         begin
            idx = rr_ptr + 2'(k);
            if (q_ready[idx])
            begin
               sel_q  = idx;
               sel_ok = 1'b1;
            end
         end
      end
      else
      begin
         for (int i = 0; i < 4; i++)
            if (q_ready[i])
            begin
               sel_q  = 2'(i);
               sel_ok = 1'b1;
            end
      end
      next_credit = base;
      if (sel_ok && wfq_on)
         next_credit[sel_q] = base[sel_q] - 5'h01;
   end

   // credits only move when a slot is actually granted
   always_ff @(posedge clk_sys or negedge rst_q)
   begin
      if (!rst_q)
      begin
         credit     <= '0;
         rr_ptr     <= 2'h0;
         pick_valid <= 1'b0;
         pick_q     <= 2'h0;
      end
      else
      begin
         pick_valid <= slot && sel_ok;
         if (slot && sel_ok)
         begin
            pick_q <= sel_q;
            rr_ptr <= sel_q;
            if (wfq_on)
               credit <= next_credit;
         end
      end
   end

   pick_busy_a : assert property (@(posedge clk_sys) disable iff (!rst_q)
      slot && |q_ready |=> pick_valid && $past(q_ready[sel_q]))
      else $error("picked queue was empty");
   strict_top_a : assert property (@(posedge clk_sys) disable iff (!rst_q)
      slot && !wfq_on && !method_rr && q_ready[3] |=> pick_q == 2'h3)
      else $error("strict priority skipped queue 3");
   wfq_empty_a : assert property (@(posedge clk_sys) disable iff (!rst_q)
      wfq_on && slot && q_ready == 4'h1 |=> pick_q == 2'h0)
      else $error("lone queue not served");
   cov_wfq_c : cover property (@(posedge clk_sys) wfq_on && slot && &q_ready);
   cov_rr_c : cover property (@(posedge clk_sys) method_rr && !wfq_on && slot);

endmodule : sgcr_egress_sched
`default_nettype wire

// *** hdl/sgcr_global_regs.sv ***
// sgcr_global_regs: frame size control, forwarding features and
// processor-port settings, with the frame checks that consume them.
// assumes the register port and frame strobes are synchronous to clk_sys.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - with the size check off, frames up to 1536 bytes are accepted.
// - with the size check on, tagged frames over 1522 and untagged over 1518 bytes drop.
// - huge packet support accepts up to 1916 bytes and overrides the size check.
// - bit 7 of the forwarding register turns tagged LAN forwarding on, reset off.
// - with snooping on every multicast join frame goes to the processor port.
// - without fair queuing each port schedules by its own per-port method bit.
// - fair queuing shares bandwidth 8:4:2:1 among queues three to zero when all are busy.
// - under fair queuing with some queue empty, the top busy queue gets one extra unit, empty queues none.
// - with sniff select set, a frame mirrors only if source and destination match.
// - with sniff select clear, a frame mirrors if source or destination matches.
// - bit 6 of the cpu port register selects half duplex when set.
// - bit 5, set at reset, enables pause flow control on the cpu port.
// - bit 4 runs the cpu port at 10 Mbps when set, 100 Mbps when clear.
// - with bit 3 set, a null VLAN id is replaced by the port default id.
module sgcr_global_regs
   import sgcr_pkg::*;
#(
   parameter int NPORT = 3
)
(
   input  wire logic             clk_sys,
   input  wire logic             rstn,
   // register port
   input  wire logic [7:0]       reg_addr,
   input  wire logic             reg_wr,
   input  wire logic [7:0]       reg_wdata,
   input  wire logic             reg_rd,
   output logic [7:0]            reg_rdata,
   output logic                  reg_rvalid,
   // frame length check
   input  wire logic             len_chk,
   input  wire logic [10:0]      frame_len,
   input  wire logic             frame_tagged,
   output logic                  len_done,
   output logic                  frame_drop,
   // multicast join snooping
   input  wire logic             fwd_chk,
   input  wire logic             frame_is_igmp,
   output logic                  fwd_done,
   output logic                  to_cpu_port,
   // mirroring
   input  wire logic             src_sniffed,
   input  wire logic             dst_sniffed,
   output logic                  mirror_frame,
   // null id replacement
   input  wire logic [11:0]      frame_vid,
   input  wire logic [11:0]      port_default_vid,
   output logic [11:0]           vid_out,
   // egress scheduling
   input  wire logic [NPORT-1:0] port_method_rr,
   input  wire logic [4*NPORT-1:0] q_ready,
   input  wire logic [NPORT-1:0] tx_slot,
   output logic [NPORT-1:0]      tx_pick_valid,
   output logic [2*NPORT-1:0]    tx_pick_q,
   // settings toward the fabric
   output logic                  tagged_lan_mode_on,
   output logic                  multicast_join_capture_on,
   output logic                  cpu_port_half_duplex,
   output logic                  cpu_port_flow_ctl,
   output logic                  cpu_port_low_speed,
   output logic                  zero_tag_id_substitute
);

   logic [1:0] rst_sync;
   logic       rst_q;
   logic [7:0] size_ctl;
   logic [7:0] fwd_feat;
   logic [7:0] cpu_set;

   // two-stage reset release; only the second stage is used
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         rst_sync <= 2'b00;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end
   assign rst_q = rst_sync[1];

   // address decode
   wire hit_ctl2 = reg_addr == SGCR_OFS_CTL2;
   wire hit_fwd  = reg_addr == SGCR_OFS_FWD;
   wire hit_cpu  = reg_addr == SGCR_OFS_CPU;

   // writes only touch r/w bits; read-only bits keep their reset value
   wire [7:0] next_size_ctl = (reg_wdata & SGCR_CTL2_MASK);
   wire [7:0] next_fwd_feat = (reg_wdata & SGCR_FWD_MASK) | (SGCR_FWD_RST & ~SGCR_FWD_MASK);
   wire [7:0] next_cpu_set  = (reg_wdata & SGCR_CPU_MASK) | (SGCR_CPU_RST & ~SGCR_CPU_MASK);

   always_ff @(posedge clk_sys or negedge rst_q)
   begin
      if (!rst_q)
      begin
         size_ctl <= SGCR_CTL2_RST;
         fwd_feat <= SGCR_FWD_RST;
         cpu_set  <= SGCR_CPU_RST;
      end
      else if (reg_wr)
      begin
         if (hit_ctl2)
            size_ctl <= next_size_ctl;
         if (hit_fwd)
            fwd_feat <= next_fwd_feat;
         if (hit_cpu)
            cpu_set <= next_cpu_set;
      end
   end

   // read mux; unmapped offsets read zero
   wire [7:0] rd_mux = hit_ctl2 ? size_ctl :
                       hit_fwd  ? fwd_feat :
                       hit_cpu  ? cpu_set  : 8'h00;

   always_ff @(posedge clk_sys or negedge rst_q)
   begin
      if (!rst_q)
      begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         reg_rvalid <= reg_rd;
         if (reg_rd)
            reg_rdata <= rd_mux;
      end
   end

   // settings are the register flops themselves
   assign tagged_lan_mode_on        = fwd_feat[SGCR_B_VLAN];
   assign multicast_join_capture_on = fwd_feat[SGCR_B_SNOOP];
   assign cpu_port_half_duplex      = cpu_set[SGCR_B_HALF];
   assign cpu_port_flow_ctl         = cpu_set[SGCR_B_FLOW];
   assign cpu_port_low_speed        = cpu_set[SGCR_B_LOW];
   assign zero_tag_id_substitute    = cpu_set[SGCR_B_NULLV];

   // size limit: huge wins over the legal check
   wire        huge_on  = size_ctl[SGCR_B_HUGE];
   wire        legal_on = size_ctl[SGCR_B_LEGAL];
   wire [10:0] tag_lim  = frame_tagged ? SGCR_LEN_TAGGED : SGCR_LEN_UNTAGGED;
   wire [10:0] len_lim  = huge_on  ? SGCR_LEN_HUGE :
                          legal_on ? tag_lim :
                                     SGCR_LEN_ANY;
   wire        too_long = frame_len > len_lim;

   // frame decisions, one cycle after the strobe
   wire sniff_hit = fwd_feat[SGCR_B_SNIFF] ? (src_sniffed && dst_sniffed)
                                           : (src_sniffed || dst_sniffed);
   wire vid_null  = frame_vid == SGCR_NULL_VID;
   wire [11:0] next_vid = (zero_tag_id_substitute && vid_null) ? port_default_vid
                                                               : frame_vid;

   always_ff @(posedge clk_sys or negedge rst_q)
   begin
      if (!rst_q)
      begin
         len_done     <= 1'b0;
         frame_drop   <= 1'b0;
         fwd_done     <= 1'b0;
         to_cpu_port  <= 1'b0;
         mirror_frame <= 1'b0;
         vid_out      <= 12'h000;
      end
      else
      begin
         len_done <= len_chk;
         fwd_done <= fwd_chk;
         if (len_chk)
            frame_drop <= too_long;
         if (fwd_chk)
         begin
            to_cpu_port  <= multicast_join_capture_on && frame_is_igmp;
            mirror_frame <= sniff_hit;
            vid_out      <= next_vid;
         end
      end
   end

   // one scheduler per egress port
   for (genvar p = 0; p < NPORT; p++)
   begin : g_port
      sgcr_egress_sched u_sched (
         .clk_sys    (clk_sys),
         .rst_q      (rst_q),
         .wfq_on     (fwd_feat[SGCR_B_WFQ]),
         .method_rr  (port_method_rr[p]),
         .q_ready    (q_ready[4*p +: 4]),
         .slot       (tx_slot[p]),
         .pick_valid (tx_pick_valid[p]),
         .pick_q     (tx_pick_q[2*p +: 2])
      );
   end

   // size verdicts, checked against plain limits rather than the package
   any_size_a : assert property (@(posedge clk_sys) disable iff (!rst_q)
      len_chk && !huge_on && !legal_on |=> len_done
      && frame_drop == ($past(frame_len) > 11'h600))
      else $error("default size limit wrong");
   legal_size_a : assert property (@(posedge clk_sys) disable iff (!rst_q)
      len_chk && !huge_on && legal_on && frame_tagged |=>
      frame_drop == ($past(frame_len) > 11'h5f2))
      else $error("tagged size limit wrong");
   untag_size_a : assert property (@(posedge clk_sys) disable iff (!rst_q)
      len_chk && !huge_on && legal_on && !frame_tagged |=>
      frame_drop == ($past(frame_len) > 11'h5ee))
      else $error("untagged size limit wrong");
   huge_size_a : assert property (@(posedge clk_sys) disable iff (!rst_q)
      len_chk && huge_on |=> frame_drop == ($past(frame_len) > 11'h77c))
      else $error("huge size limit wrong");
   drop_hold_a : assert property (@(posedge clk_sys) disable iff (!rst_q)
      !len_chk |=> !len_done && $stable(frame_drop))
      else $error("length verdict moved without a strobe");
   size_bits_a : assert property (@(posedge clk_sys) disable iff (!rst_q)
      reg_wr && hit_ctl2 |=> huge_on == $past(reg_wdata[2])
      && legal_on == $past(reg_wdata[1]))
      else $error("size control bits not written");

   // setting bits follow writes and hold otherwise
   vlan_bit_a : assert property (@(posedge clk_sys) disable iff (!rst_q)
      reg_wr && hit_fwd |=> tagged_lan_mode_on == $past(reg_wdata[7]))
      else $error("vlan mode bit not written");
   snoop_bit_a : assert property (@(posedge clk_sys) disable iff (!rst_q)
      reg_wr && hit_fwd |=> multicast_join_capture_on == $past(reg_wdata[6]))
      else $error("snoop bit not written");
   wfq_bit_a : assert property (@(posedge clk_sys) disable iff (!rst_q)
      reg_wr && hit_fwd |=> fwd_feat[SGCR_B_WFQ] == $past(reg_wdata[3]))
      else $error("fair queuing bit not written");
   fwd_hold_a : assert property (@(posedge clk_sys) disable iff (!rst_q)
      !reg_wr |=> $stable(fwd_feat))
      else $error("forwarding settings moved without a write");
   cpu_bits_a : assert property (@(posedge clk_sys) disable iff (!rst_q)
      reg_wr && hit_cpu |=> cpu_port_half_duplex == $past(reg_wdata[6])
      && cpu_port_low_speed == $past(reg_wdata[4]))
      else $error("cpu port mode bits not written");
   flow_bit_a : assert property (@(posedge clk_sys) disable iff (!rst_q)
      reg_wr && hit_cpu |=> cpu_port_flow_ctl == $past(reg_wdata[5]))
      else $error("flow control bit not written");
   nullv_bit_a : assert property (@(posedge clk_sys) disable iff (!rst_q)
      reg_wr && hit_cpu |=> zero_tag_id_substitute == $past(reg_wdata[3]))
      else $error("null id bit not written");
   flow_reset_a : assert property (@(posedge clk_sys)
      $rose(rst_q) |-> cpu_port_flow_ctl && !cpu_port_low_speed)
      else $error("cpu port reset defaults wrong");
   ro_bits_a : assert property (@(posedge clk_sys) disable iff (!rst_q)
      fwd_feat[5:4] == 2'b00 && fwd_feat[2:1] == 2'b00 && !cpu_set[7])
      else $error("read-only bit changed");

   // read answers: one-cycle valid, read-only bits show their defaults
   rd_answer_a : assert property (@(posedge clk_sys) disable iff (!rst_q)
      reg_rd |=> reg_rvalid)
      else $error("read not answered");
   rd_idle_a : assert property (@(posedge clk_sys) disable iff (!rst_q)
      !reg_rd |=> !reg_rvalid)
      else $error("read valid without a read");
   unmapped_rd_a : assert property (@(posedge clk_sys) disable iff (!rst_q)
      reg_rd && !hit_ctl2 && !hit_fwd && !hit_cpu |=> reg_rdata == 8'h00)
      else $error("unmapped offset read nonzero");
   fwd_ro_rd_a : assert property (@(posedge clk_sys) disable iff (!rst_q)
      reg_rd && hit_fwd |=> (reg_rdata & 8'h36) == 8'h00)
      else $error("forwarding read-only bits read nonzero");
   cpu_ro_rd_a : assert property (@(posedge clk_sys) disable iff (!rst_q)
      reg_rd && hit_cpu |=> (reg_rdata & 8'h87) == 8'h00)
      else $error("cpu port read-only bits read nonzero");

   // forwarding decisions
   snoop_fwd_a : assert property (@(posedge clk_sys) disable iff (!rst_q)
      fwd_chk && frame_is_igmp && multicast_join_capture_on |=> to_cpu_port)
      else $error("snooped frame not sent to cpu port");
   snoop_off_a : assert property (@(posedge clk_sys) disable iff (!rst_q)
      fwd_chk && !multicast_join_capture_on |=> !to_cpu_port)
      else $error("frame redirected with snooping off");
   sniff_and_a : assert property (@(posedge clk_sys) disable iff (!rst_q)
      fwd_chk && fwd_feat[0] && !(src_sniffed && dst_sniffed) |=> !mirror_frame)
      else $error("and sniff mirrored on one match");
   sniff_both_a : assert property (@(posedge clk_sys) disable iff (!rst_q)
      fwd_chk && src_sniffed && dst_sniffed |=> mirror_frame)
      else $error("double match not mirrored");
   sniff_or_a : assert property (@(posedge clk_sys) disable iff (!rst_q)
      fwd_chk && !fwd_feat[0] && src_sniffed |=> mirror_frame)
      else $error("or sniff missed a match");
   sniff_none_a : assert property (@(posedge clk_sys) disable iff (!rst_q)
      fwd_chk && !src_sniffed && !dst_sniffed |=> !mirror_frame)
      else $error("frame mirrored with no match");
   null_vid_a : assert property (@(posedge clk_sys) disable iff (!rst_q)
      fwd_chk && zero_tag_id_substitute && frame_vid == 12'h000 |=>
      vid_out == $past(port_default_vid))
      else $error("null id not replaced");
   vid_keep_a : assert property (@(posedge clk_sys) disable iff (!rst_q)
      fwd_chk && frame_vid != 12'h000 |=> vid_out == $past(frame_vid))
      else $error("non-null id altered");
   vid_off_a : assert property (@(posedge clk_sys) disable iff (!rst_q)
      fwd_chk && !zero_tag_id_substitute |=> vid_out == $past(frame_vid))
      else $error("id replaced with replacement off");
   fwd_outs_hold_a : assert property (@(posedge clk_sys) disable iff (!rst_q)
      !fwd_chk |=> !fwd_done && $stable(to_cpu_port)
      && $stable(mirror_frame) && $stable(vid_out))
      else $error("forwarding result moved without a strobe");
   cov_drop_c : cover property (@(posedge clk_sys) len_done && frame_drop);
   cov_snoop_c : cover property (@(posedge clk_sys) fwd_done && to_cpu_port);
   cov_mirror_c : cover property (@(posedge clk_sys) fwd_done && mirror_frame);

endmodule : sgcr_global_regs
`default_nettype wire

// *** tb/sgcr_global_regs_tb_top.sv ***
// sgcr_global_regs_tb_top: self-checking bench for the global control slice.
// assumes sgcr_pkg and sgcr_global_regs are compiled first; one 125 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module sgcr_global_regs_tb_top
   import sgcr_pkg::*;
;
   logic        clk_sys = 1'b0;
   logic        rstn = 1'b1;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata;
   logic        reg_wr, reg_rd, reg_rvalid;
   logic        len_chk, frame_tagged, len_done, frame_drop;
   logic [10:0] frame_len;
   logic        fwd_chk, frame_is_igmp, fwd_done, to_cpu_port;
   logic        src_sniffed, dst_sniffed, mirror_frame;
   logic [11:0] frame_vid, port_default_vid, vid_out, q_ready;
   logic [2:0]  port_method_rr, tx_slot, tx_pick_valid;
   logic [5:0]  tx_pick_q, flags;
   logic        tagged_lan_mode_on, multicast_join_capture_on, cpu_port_half_duplex;
   logic        cpu_port_flow_ctl, cpu_port_low_speed, zero_tag_id_substitute;
   int          failures = 0;
   int          n_checks = 0;
   int          cnt [3][4];

   // free-running system clock, 8 ns
   always #4 clk_sys = ~clk_sys;

   // fabric settings gathered for compact compares
   assign flags = {tagged_lan_mode_on, multicast_join_capture_on, cpu_port_half_duplex,
                   cpu_port_flow_ctl, cpu_port_low_speed, zero_tag_id_substitute};

   sgcr_global_regs #(.NPORT(3)) dut (
      .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .len_chk(len_chk), .frame_len(frame_len), .frame_tagged(frame_tagged),
      .len_done(len_done), .frame_drop(frame_drop), .fwd_chk(fwd_chk),
      .frame_is_igmp(frame_is_igmp), .fwd_done(fwd_done), .to_cpu_port(to_cpu_port),
      .src_sniffed(src_sniffed), .dst_sniffed(dst_sniffed), .mirror_frame(mirror_frame),
      .frame_vid(frame_vid), .port_default_vid(port_default_vid), .vid_out(vid_out),
      .port_method_rr(port_method_rr), .q_ready(q_ready), .tx_slot(tx_slot),
      .tx_pick_valid(tx_pick_valid), .tx_pick_q(tx_pick_q),
      .tagged_lan_mode_on(tagged_lan_mode_on),
      .multicast_join_capture_on(multicast_join_capture_on),
      .cpu_port_half_duplex(cpu_port_half_duplex), .cpu_port_flow_ctl(cpu_port_flow_ctl),
      .cpu_port_low_speed(cpu_port_low_speed),
      .zero_tag_id_substitute(zero_tag_id_substitute));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // register write: strobe for one edge, look after it lands
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      #1;
   endtask

   // register read: answer is due right after the taking edge
   task automatic reg_check(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      check(reg_rvalid, 1'b1);
      check(reg_rdata, exp);
   endtask

   // one forwarding decision with a fixed port default id
   task automatic fwd(input logic igmp, input logic s, input logic d, input logic [11:0] v);
      @(posedge clk_sys);
      fwd_chk <= 1'b1;
      frame_is_igmp <= igmp;
      src_sniffed <= s;
      dst_sniffed <= d;
      frame_vid <= v;
      port_default_vid <= 12'h5a3;
      @(posedge clk_sys);
      fwd_chk <= 1'b0;
      #1;
      check(fwd_done, 1'b1);
   endtask

   // n back-to-back slots on all three ports, picks tallied per queue
   task automatic run_slots(input logic [11:0] q, input logic [2:0] rr, input int n);
      cnt = '{default: 0};
      @(posedge clk_sys);
      q_ready <= q;
      port_method_rr <= rr;
      tx_slot <= 3'b111;
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk_sys);
         if (i == n - 1)
            tx_slot <= 3'b000;
         #1;
         for (int p = 0; p < 3; p++)
            if (tx_pick_valid[p] === 1'b1)
               cnt[p][tx_pick_q[2*p +: 2]]++;
      end
   endtask

   function automatic logic [15:0] tally(input int p);
      return {cnt[p][3][3:0], cnt[p][2][3:0], cnt[p][1][3:0], cnt[p][0][3:0]};
   endfunction

   task automatic t_reset();
      check(flags, 6'h04);
      reg_check(8'h04, 8'h00);
      reg_check(8'h05, 8'h00);
      reg_check(8'h06, 8'h20);
      reg_check(8'h07, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_regs();
      reg_write(8'h05, 8'hff);
      reg_check(8'h05, 8'hc9);
      reg_write(8'h05, 8'h80); // vlan table taken as loaded
      check(flags[5:4], 2'b10);
      reg_write(8'h05, 8'h40);
      check(flags[5:4], 2'b01);
      reg_write(8'h06, 8'hff);
      reg_check(8'h06, 8'h78);
      // walk one bit at a time so a swapped field shows
      for (int i = 3; i < 7; i++)
      begin
         reg_write(8'h06, 8'h01 << i);
         check(flags[3:0], 4'h1 << (i - 3));
      end
      reg_write(8'h07, 8'hff);
      reg_check(8'h07, 8'h00);
      reg_write(8'h04, 8'hfe); // reserved bit 0 kept at 0
      reg_check(8'h04, 8'h06);
      $display("test registers done");
   endtask

   task automatic t_len();
      logic [7:0]  ctl [8] = '{8'h00, 8'h00, 8'h02, 8'h02, 8'h02, 8'h02, 8'h06, 8'h04};
      logic [10:0] len [8] = '{11'd1536, 11'd1537, 11'd1518, 11'd1519,
                               11'd1522, 11'd1523, 11'd1916, 11'd1917};
      logic        tag [8] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
      logic        drop [8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
      for (int i = 0; i < 8; i++)
      begin
         reg_write(8'h04, ctl[i]);
         @(posedge clk_sys);
         len_chk <= 1'b1;
         frame_len <= len[i];
         frame_tagged <= tag[i];
         @(posedge clk_sys);
         len_chk <= 1'b0;
         #1;
         check(len_done, 1'b1);
         check(frame_drop, drop[i]);
      end
      $display("test length done");
   endtask

   task automatic t_fwd();
      reg_write(8'h05, 8'h40);
      fwd(1'b1, 1'b0, 1'b0, 12'h001);
      check(to_cpu_port, 1'b1);
      fwd(1'b0, 1'b0, 1'b0, 12'h001);
      check(to_cpu_port, 1'b0);
      reg_write(8'h05, 8'h00);
      fwd(1'b1, 1'b0, 1'b0, 12'h001);
      check(to_cpu_port, 1'b0);
      // every match combination under both mirror modes
      for (int m = 0; m < 2; m++)
      begin
         reg_write(8'h05, m[7:0]);
         for (int sd = 0; sd < 4; sd++)
         begin
            fwd(1'b0, sd[1], sd[0], 12'h005);
            check(mirror_frame, m ? (sd == 3) : (sd != 0));
         end
      end
      reg_write(8'h06, 8'h08);
      fwd(1'b0, 1'b0, 1'b0, 12'h000);
      check(vid_out, 12'h5a3);
      fwd(1'b0, 1'b0, 1'b0, 12'h123);
      check(vid_out, 12'h123);
      reg_write(8'h06, 8'h20);
      fwd(1'b0, 1'b0, 1'b0, 12'h000);
      check(vid_out, 12'h000);
      $display("test forwarding done");
   endtask

   task automatic t_sched();
      reg_write(8'h05, 8'h08);
      run_slots(12'hfff, 3'b000, 15);
      for (int p = 0; p < 3; p++)
         check(tally(p), 16'h8421);
      run_slots(12'hbbb, 3'b000, 12);
      for (int p = 0; p < 3; p++)
         check(tally(p), 16'h9021);
      // one lone busy queue per port
      run_slots(12'h124, 3'b000, 3);
      check(tally(0), 16'h0300);
      check(tally(1), 16'h0030);
      check(tally(2), 16'h0003);
      // strict on port 0, rotation on port 1, nothing ready on port 2
      reg_write(8'h05, 8'h00);
      run_slots(12'h0fe, 3'b010, 4);
      check(tally(0), 16'h4000);
      check(tally(1), 16'h1111);
      check(tally(2), 16'h0000);
      $display("test scheduler done");
   endtask

   // main sequence: all inputs defined at time zero, reset held 20 cycles
   initial
   begin
      {reg_addr, reg_wdata, reg_wr, reg_rd, len_chk, frame_len, frame_tagged} = '0;
      {fwd_chk, frame_is_igmp, src_sniffed, dst_sniffed, frame_vid} = '0;
      {port_default_vid, port_method_rr, q_ready, tx_slot} = '0;
      // pull reset after time zero so its falling edge is seen
      #1 rstn = 1'b0;
      repeat (20) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      t_reset();
      t_regs();
      t_len();
      t_fwd();
      t_sched();
      tally_and_finish();
   end

   // watchdog: a hang counts as a mismatch
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      failures++;
      tally_and_finish();
   end
endmodule // sgcr_global_regs_tb_top
`default_nettype wire
